// ===== design/pxt_core.sv
// Instruction timing engine with two-wire debug and programming access.
`include "pxt_defines.svh"
module pxt_core (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Program memory, data valid one clock after the address.
  output logic [15:0] code_addr,
  input wire logic [7:0] code_data,
  // Execution datapath status.
  input wire logic cond_true,
  input wire logic redirect,
  input wire logic [15:0] redirect_target,
  // Instruction progress.
  output logic [7:0] opcode,
  output logic [1:0] insn_len,
  output logic insn_start,
  output logic insn_busy,
  output logic insn_done,
  output logic halted,
  // Two-wire development pins.
  input wire logic dbg_clk_pin,
  input wire logic dbg_data_in,
  output logic dbg_data_out,
  output logic dbg_data_oe_n,
  // Debug memory access for memory, registers and flash.
  output logic dbg_wr,
  output logic dbg_rd,
  output logic [7:0] dbg_space,
  output logic [15:0] dbg_addr,
  output logic [7:0] dbg_wdata,
  input wire logic [7:0] dbg_rdata
);
  pxt_dec_if dif ();
  pxt_pkg::pxt_state_t state;
  logic [15:0] pc;
  logic [3:0] cnt;
  logic taken_q;
  logic taken_now;
  logic [3:0] limit;
  logic [7:0] cur_op;
  logic [15:0] bp_addr;
  logic bp_en;
  logic step_armed;
  logic bp_hit;
  logic ck_s1, ck_s2, ck_s3, dt_s1, dt_s2;
  logic ck_rise;
  logic [23:0] in_sr;
  logic [4:0] in_cnt;
  logic [15:0] out_sr;
  logic [4:0] out_cnt;
  logic cmd_valid;
  logic [7:0] cmd;
  logic [15:0] arg;
  logic rd_pend;

  pxt_dec_rom u_rom (
    .clock(clock),
    .reset_n(reset_n),
    .dif(dif.rom)
  );

  // The table looks up whatever byte the program memory returns.
  assign dif.opcode = code_data;
  assign code_addr = pc;
  assign opcode = cur_op;
  assign insn_len = dif.dec.len;
  assign insn_busy = (state == pxt_pkg::PXT_EXEC);
  assign insn_start = insn_busy && (cnt == 4'h1);
  assign taken_now = dif.dec.cond && (insn_start ? cond_true : taken_q);
  assign limit = dif.dec.cycles + {3'h0, taken_now};
  assign insn_done = insn_busy && (cnt == limit);
  assign bp_hit = bp_en && (pc == bp_addr) && !step_armed;

  // Sequencer: flush, fetch, decode, then count the execute clocks.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      state <= pxt_pkg::PXT_FLUSH;
    else
      unique case (state)
        pxt_pkg::PXT_FLUSH: state <= pxt_pkg::PXT_FETCH;
        pxt_pkg::PXT_FETCH: if (!halted && !bp_hit) state <= pxt_pkg::PXT_DECODE;
        pxt_pkg::PXT_DECODE: state <= pxt_pkg::PXT_EXEC;
        pxt_pkg::PXT_EXEC: if (insn_done) state <= pxt_pkg::PXT_FETCH;
      endcase
  end

  // Clock counter within one instruction, and the branch outcome.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt <= 4'h0;
      taken_q <= 1'b0;
    end
    else
    begin
      cnt <= (state == pxt_pkg::PXT_DECODE) ? 4'h1 : (insn_busy && !insn_done) ? cnt + 4'h1 : 4'h0;
      if (insn_start)
        taken_q <= cond_true;
    end
  end

  // Program counter starts at the reset vector and steps by length.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      pc <= `PXT_RESET_VECTOR;
    else if (state == pxt_pkg::PXT_FLUSH)
      pc <= `PXT_RESET_VECTOR;
    else if (insn_done)
      pc <= redirect ? redirect_target : pc + {14'h0, dif.dec.len};
  end

  // Holds the opcode of the instruction in flight.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      cur_op <= 8'h00;
    else if (state == pxt_pkg::PXT_DECODE)
      cur_op <= code_data;
  end

  // Two-flop synchronisers for the debug pins, plus an edge stage.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      {ck_s1, ck_s2, ck_s3, dt_s1, dt_s2} <= 5'h00;
    else
      {ck_s1, ck_s2, ck_s3, dt_s1, dt_s2} <= {dbg_clk_pin, ck_s1, ck_s2, dbg_data_in, dt_s1};
  end
  assign ck_rise = ck_s2 && !ck_s3;

  // Shifts frames in, or a reply out, on each rising debug clock.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      in_sr <= 24'h000000;
      in_cnt <= 5'h00;
      out_sr <= 16'h0000;
      out_cnt <= 5'h00;
      cmd_valid <= 1'b0;
    end
    else
    begin
      cmd_valid <= 1'b0;
      if (rd_pend)
      begin
        out_sr <= {8'h00, dbg_rdata};
        out_cnt <= `PXT_REPLY_BITS;
      end
      else if (cmd_valid && (cmd == `PXT_CMD_READ_PC))
      begin
        out_sr <= pc;
        out_cnt <= `PXT_REPLY_BITS;
      end
      else if (cmd_valid && (cmd == `PXT_CMD_STATUS))
      begin
        out_sr <= {bp_en, step_armed, halted, 5'h00, cur_op};
        out_cnt <= `PXT_REPLY_BITS;
      end
      else if (ck_rise && (out_cnt != 5'h00))
      begin
        out_sr <= {out_sr[14:0], 1'b0};
        out_cnt <= out_cnt - 5'h01;
      end
      else if (ck_rise)
      begin
        in_sr <= {in_sr[22:0], dt_s2};
        cmd_valid <= (in_cnt == `PXT_FRAME_BITS - 5'h01);
        in_cnt <= (in_cnt == `PXT_FRAME_BITS - 5'h01) ? 5'h00 : in_cnt + 5'h01;
      end
    end
  end
  assign cmd = in_sr[23:16];
  assign arg = in_sr[15:0];
  assign dbg_data_out = out_sr[15];
  assign dbg_data_oe_n = (out_cnt == 5'h00);

  // Run control: halt, run, step and breakpoints; a stop wins over a run.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      halted <= 1'b0;
      step_armed <= 1'b0;
      bp_en <= 1'b0;
      bp_addr <= 16'h0000;
    end
    else
    begin
      if (cmd_valid && (cmd == `PXT_CMD_SET_BP))
      begin
        bp_addr <= arg;
        bp_en <= 1'b1;
      end
      if (cmd_valid && (cmd == `PXT_CMD_CLR_BP))
        bp_en <= 1'b0;
      if (cmd_valid && (cmd == `PXT_CMD_STEP) && halted)
        step_armed <= 1'b1;
      else if (insn_done)
        step_armed <= 1'b0;
      if ((cmd_valid && (cmd == `PXT_CMD_HALT)) || (state == pxt_pkg::PXT_FETCH && bp_hit) ||
          (insn_done && step_armed))
        halted <= 1'b1;
      else if (cmd_valid && ((cmd == `PXT_CMD_RUN) || (cmd == `PXT_CMD_STEP)))
        halted <= 1'b0;
    end
  end

  // Memory access, only while halted so the application is untouched.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dbg_wr <= 1'b0;
      dbg_rd <= 1'b0;
      rd_pend <= 1'b0;
      dbg_space <= 8'h00;
      dbg_addr <= 16'h0000;
      dbg_wdata <= 8'h00;
    end
    else
    begin
      rd_pend <= dbg_rd;
      dbg_wr <= cmd_valid && halted && (cmd == `PXT_CMD_WRITE);
      dbg_rd <= cmd_valid && halted && (cmd == `PXT_CMD_READ);
      if (cmd_valid && (cmd == `PXT_CMD_SET_ADDR))
        dbg_addr <= arg;
      if (cmd_valid && halted && ((cmd == `PXT_CMD_WRITE) || (cmd == `PXT_CMD_READ)))
      begin
        dbg_space <= arg[15:8];
        dbg_wdata <= arg[7:0];
      end
      else if (dbg_wr || rd_pend)
        dbg_addr <= dbg_addr + 16'h0001;
    end
  end

  exec_bound_a: assert property (@(posedge clock) disable iff (!reset_n)
    insn_busy |-> cnt <= `PXT_MAX_CYCLES) else $error("instruction over eight clocks");
  div_time_a: assert property (@(posedge clock) disable iff (!reset_n)
    insn_done && cur_op == `PXT_OP_DIV |-> cnt == 4'h8) else $error("divide not eight clocks");
  branch_extra_a: assert property (@(posedge clock) disable iff (!reset_n)
    insn_done && dif.dec.cond |-> cnt == dif.dec.cycles + {3'h0, taken_q || (insn_start && cond_true)})
    else $error("branch clock count wrong");
  add_reg_a: assert property (@(posedge clock) disable iff (!reset_n)
    insn_start && cur_op[7:3] inside {5'h05, 5'h07, 5'h13} |-> insn_done && insn_len == 2'h1)
    else $error("register add not one clock");
  add_direct_a: assert property (@(posedge clock) disable iff (!reset_n)
    insn_start && cur_op inside {8'h25, 8'h35, 8'h95} |-> !insn_done ##1 insn_done && insn_len == 2'h2)
    else $error("direct add not two clocks");
  indirect_op_a: assert property (@(posedge clock) disable iff (!reset_n)
    insn_start && cur_op[3:1] == 3'h3 && cur_op[7:4] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9}
    |-> insn_len == 2'h1 && !insn_done ##1 insn_done) else $error("indirect op not two clocks");
  imm_arith_a: assert property (@(posedge clock) disable iff (!reset_n)
    insn_start && cur_op inside {8'h24, 8'h34, 8'h94} |-> ##1 insn_done) else $error("immediate op not two clocks");
  logic_imm_a: assert property (@(posedge clock) disable iff (!reset_n)
    insn_start && cur_op inside {8'h43, 8'h53, 8'h63} |-> insn_len == 2'h3 ##2 insn_done)
    else $error("logic immediate not three clocks");
  logic_dir_a: assert property (@(posedge clock) disable iff (!reset_n)
    insn_start && cur_op inside {8'h42, 8'h52, 8'h62} |-> insn_len == 2'h2 ##1 insn_done)
    else $error("logic to direct not two clocks");
  reset_vec_a: assert property (@(posedge clock) disable iff (!reset_n)
    state == pxt_pkg::PXT_FLUSH |=> pc == `PXT_RESET_VECTOR && state == pxt_pkg::PXT_FETCH)
    else $error("reset did not start at vector");
  halt_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    halted && state == pxt_pkg::PXT_FETCH |=> state == pxt_pkg::PXT_FETCH || !$past(halted))
    else $error("core ran while halted");
endmodule // pxt_core

// ===== design/pxt_dec_if.sv
// Opcode and decoded timing passed between the engine and the table.
interface pxt_dec_if;
  logic [7:0] opcode;
  pxt_pkg::pxt_dec_t dec;
  modport core (output opcode, input dec);
  modport rom (input opcode, output dec);
endinterface

// ===== design/pxt_dec_rom.sv
// Registered opcode table giving length, clock count and branch class.
`include "pxt_defines.svh"
module pxt_dec_rom (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Table port.
  pxt_dec_if.rom dif
);
  pxt_pkg::pxt_dec_t table_q [256];

  // Maps one opcode to its byte length, clock count and condition flag.
  function automatic pxt_pkg::pxt_dec_t entry(input logic [7:0] op);
    pxt_pkg::pxt_dec_t e;
    e.len = 2'h1;
    e.cond = 1'b0;
    casez (op)
      8'h02, 8'h12, 8'h10, 8'h20, 8'h30, 8'h43, 8'h53, 8'h63, 8'h75, 8'h85,
      8'h90, 8'hb4, 8'hb5, 8'hb6, 8'hb7, 8'b1011_1???, 8'hd5:
        e.len = 2'h3;
      8'b???0_0001, 8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'ha0, 8'hb0, 8'hc0,
      8'hd0, 8'h42, 8'h52, 8'h62, 8'h72, 8'h82, 8'h92, 8'ha2, 8'hb2, 8'hc2,
      8'hd2, 8'h24, 8'h34, 8'h44, 8'h54, 8'h64, 8'h74, 8'h94, 8'b????_0101,
      8'h76, 8'h77, 8'h86, 8'h87, 8'ha6, 8'ha7, 8'b0111_1???, 8'b1000_1???,
      8'b1010_1???, 8'b1101_1???, 8'b???1_0001:
        e.len = 2'h2;
      default:
        e.len = 2'h1;
    endcase
    // Most instructions take as many clocks as bytes.
    e.cycles = {2'h0, e.len};
    casez (op)
      `PXT_OP_MUL: e.cycles = 4'h4;
      `PXT_OP_DIV: e.cycles = `PXT_MAX_CYCLES;
      8'h83, 8'h93, 8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3: e.cycles = 4'h3;
      8'b????_011?: if (e.len == 2'h1) e.cycles = 4'h2;
      default: e.cycles = {2'h0, e.len};
    endcase
    casez (op)
      8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h70, 8'b1011_????, 8'hd5,
      8'b1101_1???:
        e.cond = (op != 8'hb0) && (op != 8'hb1) && (op != 8'hb2) && (op != 8'hb3);
      default: e.cond = 1'b0;
    endcase
    return e;
  endfunction

  // Builds the table, one entry per opcode, in the standard encoding.
  for (genvar i = 0; i < 256; i++)
  begin : g_tab
    assign table_q[i] = entry(8'(i));
  end

  // Read data leaves through a register.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      dif.dec <= '0;
    else
      dif.dec <= table_q[dif.opcode];
  end
endmodule // pxt_dec_rom

// ===== design/pxt_defines.svh
// Constants for the sequential instruction timing engine.
`ifndef PXT_DEFINES_SVH
`define PXT_DEFINES_SVH
`define PXT_RESET_VECTOR 16'h0000
`define PXT_MAX_CYCLES 4'h8
`define PXT_OP_MUL 8'ha4
`define PXT_OP_DIV 8'h84
`define PXT_FRAME_BITS 5'h18
`define PXT_REPLY_BITS 5'h10
`define PXT_CMD_HALT 8'h01
`define PXT_CMD_RUN 8'h02
`define PXT_CMD_STEP 8'h03
`define PXT_CMD_SET_BP 8'h04
`define PXT_CMD_CLR_BP 8'h05
`define PXT_CMD_READ_PC 8'h06
`define PXT_CMD_SET_ADDR 8'h07
`define PXT_CMD_WRITE 8'h08
`define PXT_CMD_READ 8'h09
`define PXT_CMD_STATUS 8'h0a
`define PXT_ST_FLUSH 4'h1
`define PXT_ST_FETCH 4'h2
`define PXT_ST_DECODE 4'h4
`define PXT_ST_EXEC 4'h8
`endif

// ===== design/pxt_pkg.sv
// Types shared by the instruction timing engine and its decode table.
`include "pxt_defines.svh"
package pxt_pkg;
  typedef enum logic [3:0] {
    PXT_FLUSH = `PXT_ST_FLUSH,
    PXT_FETCH = `PXT_ST_FETCH,
    PXT_DECODE = `PXT_ST_DECODE,
    PXT_EXEC = `PXT_ST_EXEC
  } pxt_state_t;

  typedef struct packed {
    logic [1:0] len;
    logic [3:0] cycles;
    logic cond;
  } pxt_dec_t;
endpackage

// ===== testbench/pxt_prog_mem.sv
// Program memory and debug memory model facing the instruction timing engine.
module pxt_prog_mem (
  // Clock.
  input wire logic clock,
  // Program fetch.
  input wire logic [15:0] code_addr,
  output logic [7:0] code_data,
  // Debug memory access.
  input wire logic dbg_wr,
  input wire logic dbg_rd,
  input wire logic [7:0] dbg_space,
  input wire logic [15:0] dbg_addr,
  input wire logic [7:0] dbg_wdata,
  output logic [7:0] dbg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:63];
  logic [31:0] wr_log = 32'h0;
  int wr_count = 0;

  // Code above the loaded area reads as one-byte no-ops, so a free-running core never replays it.
  assign code_data = (code_addr < 16'h0040) ? mem[code_addr[5:0]] : 8'h00;

  // Writes are logged; read data lands one clock after the strobe and toggles otherwise.
  always @(posedge clock)
  begin
    if (dbg_wr)
    begin
      wr_log <= {dbg_addr, dbg_space, dbg_wdata};
      wr_count <= wr_count + 1;
    end
    dbg_rdata <= dbg_rd ? (dbg_addr[7:0] ^ 8'h5a) : ~dbg_rdata;
  end
endmodule // pxt_prog_mem

// ===== testbench/tb_top.sv
// Self-checking bench for the instruction timing engine and its two-wire debug link.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset_n, cond_true, redirect, dbg_clk_pin, host_bit, dbg_pin;
  logic [15:0] redirect_target, code_addr, dbg_addr;
  logic [7:0] code_data, opcode, dbg_space, dbg_wdata, dbg_rdata;
  logic [1:0] insn_len;
  logic insn_start, insn_busy, insn_done, halted, dbg_data_out, dbg_data_oe_n, dbg_wr, dbg_rd;
  int bad_count = 0;
  int n_compared = 0;
  int n_starts = 0;
  // Opcode, bytes, clocks, flags (bit 0 condition true, bit 1 redirect).
  localparam logic [19:0] PROG [23] = '{20'h28110, 20'h38110, 20'h98110, 20'h25220, 20'h35220, 20'h95220,
    20'h26120, 20'h37120, 20'h97120, 20'h24220, 20'h34220, 20'h94220, 20'h53330, 20'h43330, 20'h63330,
    20'h52220, 20'h42220, 20'h62220, 20'h56120, 20'h47120, 20'h67120, 20'ha4140, 20'h84180};

  // The shared data pin carries the device's bit whenever it drives.
  assign dbg_pin = dbg_data_oe_n ? host_bit : dbg_data_out;

  pxt_core pxt_core_inst (.clock, .reset_n, .code_addr, .code_data, .cond_true, .redirect, .redirect_target,
    .opcode, .insn_len, .insn_start, .insn_busy, .insn_done, .halted, .dbg_clk_pin, .dbg_data_in(dbg_pin),
    .dbg_data_out, .dbg_data_oe_n, .dbg_wr, .dbg_rd, .dbg_space, .dbg_addr, .dbg_wdata, .dbg_rdata);

  pxt_prog_mem pxt_prog_mem_inst (.clock, .code_addr, .code_data, .dbg_wr, .dbg_rd, .dbg_space, .dbg_addr,
    .dbg_wdata, .dbg_rdata);

  // Clock at 200 MHz.
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Counts every instruction start, so a scenario also sees starts that fall inside a frame.
  always @(negedge clock)
  begin
    if (insn_start === 1'b1)
      n_starts++;
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic count_starts(int cycles, output int n);
    n = 0;
    repeat (cycles)
    begin
      @(negedge clock);
      if (insn_start === 1'b1)
        n++;
    end
  endtask

  // Sends one 24-bit frame, most significant bit first; the debug clock idles low between frames.
  task automatic dbg_send(logic [7:0] cmd, logic [15:0] arg);
    logic [23:0] f;
    f = {cmd, arg};
    for (int i = 23; i >= 0; i--)
    begin
      host_bit = f[i];
      repeat (5) @(negedge clock);
      dbg_clk_pin = 1'b1;
      repeat (5) @(negedge clock);
      dbg_clk_pin = 1'b0;
    end
    host_bit = ~f[0];
    repeat (10) @(negedge clock);
  endtask

  // Clocks a 16-bit reply out of the device, taking each bit before the edge that retires it.
  task automatic dbg_reply(output logic [15:0] r);
    check("pin driven", dbg_data_oe_n, 1'b0);
    for (int i = 15; i >= 0; i--)
    begin
      r[i] = dbg_pin;
      dbg_clk_pin = 1'b1;
      repeat (5) @(negedge clock);
      dbg_clk_pin = 1'b0;
      repeat (5) @(negedge clock);
    end
    check("pin released", dbg_data_oe_n, 1'b1);
  endtask

  // Runs the opcode table straight from reset and times every instruction.
  task automatic run_timing();
    int n, d;
    logic [15:0] a;
    a = 16'h0000;
    for (int i = 0; i < 23 + 2; i++)
    begin
      logic [19:0] e;
      e = (i == 23) ? 20'h60220 : (i == 24) ? 20'h70233 : PROG[i];
      check("fetch address", code_addr, a);
      cond_true = e[0];
      redirect = e[1];
      n = 0;
      while (insn_start !== 1'b1 && n < 20)
      begin
        @(negedge clock);
        n++;
      end
      check("opcode", opcode, e[19:12]);
      check("length", insn_len, e[11:8]);
      n = 0;
      d = 0;
      while (insn_busy === 1'b1 && n < 20)
      begin
        n++;
        if (insn_done === 1'b1)
          d = n;
        @(negedge clock);
      end
      check("clocks", n, e[7:4]);
      check("done clock", d, e[7:4]);
      redirect = 1'b0;
      cond_true = 1'b0;
      a = a + e[11:8];
    end
    check("redirect target", code_addr, 16'h0040);
  endtask

  // Halts, inspects, writes and reads memory, steps, and stops on a breakpoint.
  task automatic run_debug();
    int n, s;
    logic [15:0] r, p;
    dbg_send(8'h01, 16'h0000);
    count_starts(30, n);
    check("halt stall", n, 0);
    check("halted", halted, 1'b1);
    dbg_send(8'h0a, 16'h0000);
    dbg_reply(r);
    check("status halted", r[13], 1'b1);
    check("status word", r, 16'h2000);
    dbg_send(8'h07, 16'h0010);
    dbg_send(8'h08, 16'h02a5);
    check("write", pxt_prog_mem_inst.wr_log, 32'h001002a5);
    check("write pulses", pxt_prog_mem_inst.wr_count, 1);
    dbg_send(8'h09, 16'h0200);
    dbg_reply(r);
    check("read", r, 16'h004b);
    dbg_send(8'h06, 16'h0000);
    dbg_reply(p);
    s = n_starts;
    dbg_send(8'h03, 16'h0000);
    count_starts(30, n);
    check("step count", n_starts - s, 1);
    check("step stall", n, 0);
    dbg_send(8'h06, 16'h0000);
    dbg_reply(r);
    check("step pc", r, p + 16'h0001);
    dbg_send(8'h04, p + 16'h0004);
    s = n_starts;
    dbg_send(8'h02, 16'h0000);
    count_starts(30, n);
    check("break address", code_addr, p + 16'h0004);
    check("break stall", n, 0);
    check("break starts", n_starts - s, 3);
    dbg_send(8'h05, 16'h0000);
    dbg_send(8'h02, 16'h0000);
    count_starts(30, n);
    check("resumed", n > 0, 1'b1);
  endtask

  // Watchdog well beyond the expected run of about 4000 clocks.
  initial
  begin
    repeat (40000) @(posedge clock);
    bad_count++;
    results();
  end

  // Main sequence.
  initial
  begin
    reset_n = 1'b0;
    cond_true = 1'b0;
    redirect = 1'b0;
    redirect_target = 16'h0040;
    dbg_clk_pin = 1'b0;
    host_bit = 1'b0;
    for (int i = 0; i < 64; i++)
      pxt_prog_mem_inst.mem[i] = 8'h01;
    for (int i = 0, a = 0; i < 25; i++)
    begin
      pxt_prog_mem_inst.mem[a] = (i == 23) ? 8'h60 : (i == 24) ? 8'h70 : PROG[i][19:12];
      a += (i > 22) ? 2 : PROG[i][11:8];
    end
    repeat (5) @(negedge clock);
    check("reset address", code_addr, 16'h0000);
    check("reset busy", insn_busy, 1'b0);
    check("reset pin", dbg_data_oe_n, 1'b1);
    reset_n = 1'b1;
    run_timing();
    run_debug();
    results();
  end
endmodule // tb_top
